// File: core/tpw_pkg.sv
// package for the 16-bit timer pwm block
package tpw_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_CNT    = 8'h04;
	localparam logic [7:0] OFS_CMPA   = 8'h08;
	localparam logic [7:0] OFS_CMPB   = 8'h0C;
	localparam logic [7:0] OFS_CAPTOP = 8'h10;
	localparam logic [7:0] OFS_FLAGS  = 8'h14;
	// ctrl field positions
	localparam int CTRL_WGM_LSB  = 0;
	localparam int CTRL_COMA_LSB = 4;
	localparam int CTRL_COMB_LSB = 6;
	localparam int CTRL_CS_LSB   = 8;
	localparam int CTRL_DIRA     = 11;
	localparam int CTRL_DIRB     = 12;
	// flag bit positions
	localparam int FLG_OVF  = 0;
	localparam int FLG_CMPA = 1;
	localparam int FLG_CMPB = 2;
	localparam int FLG_CAP  = 3;
	// fixed top values
	localparam logic [15:0] TOP_8BIT  = 16'h00FF;
	localparam logic [15:0] TOP_9BIT  = 16'h01FF;
	localparam logic [15:0] TOP_10BIT = 16'h03FF;
	localparam logic [15:0] BOTTOM    = 16'h0000;
	// prescaler division counts
	localparam logic [9:0] DIV_8    = 10'h007;
	localparam logic [9:0] DIV_64   = 10'h03F;
	localparam logic [9:0] DIV_256  = 10'h0FF;
	localparam logic [9:0] DIV_1024 = 10'h3FF;
	// reset values
	localparam logic [12:0] CTRL_RST = 13'h0000;
	localparam logic [15:0] VAL_RST  = 16'h0000;
	// axi response codes
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// compare output modes
	localparam logic [1:0] COM_OFF  = 2'h0;
	localparam logic [1:0] COM_TOG  = 2'h1;
	localparam logic [1:0] COM_NINV = 2'h2;

	typedef struct packed {
		logic       dir_b;
		logic       dir_a;
		logic [2:0] clk_sel;
		logic [1:0] com_b;
		logic [1:0] com_a;
		logic [3:0] wgm;
	} tpw_ctrl_t;

	typedef struct packed {
		logic [7:0]  awaddr;
		logic        awvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        wvalid;
		logic        bready;
		logic [7:0]  araddr;
		logic        arvalid;
		logic        rready;
	} tpw_axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic [1:0]  bresp;
		logic        bvalid;
		logic        arready;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        rvalid;
	} tpw_axi_rsp_t;
endpackage

// File: core/tpw_top.sv
// timer pwm top: fast and phase correct pwm, axi4-lite registers
//
// Behaviour
// - fast pwm modes 5,6,7,14,15 count up bottom to top then restart.
// - fast pwm top is 0xFF/0x1FF/0x3FF, capture top, or compare a; clear after top.
// - fast pwm mode 2 sets on match, clears at wrap; mode 3 inverted.
// - fast pwm overflow flag at top; compare a or capture flag with it.
// - fixed top masks compare bits above resolution on write.
// - capture top unbuffered; written below count, counter runs to 0xFFFF and wraps.
// - fast pwm compare a buffered, loaded at top with clear and overflow.
// - compare flag set on a tick in a pwm mode when count equals compare value.
// - compare 0 gives one-cycle spike each period; compare equal top gives constant level.
// - fast pwm mode 15 compare a mode 1 toggles output on each match.
// - phase correct modes 1,2,3,10,11 count up to top then down to bottom.
// - phase correct top fixed, capture top or compare a; top held one cycle.
// - phase correct mode 2 clears on up match, sets on down match; 3 inverts.
// - phase correct overflow flag at bottom.
// - phase correct buffers load at top; compare a or capture flag then.
// - phase correct compare bottom holds low, top holds high; inverted opposite.
// - compare output reaches pin only when its direction bit is output.
// - timer tick is clock divided by 1, 8, 64, 256 or 1024.
// - compare mode zero leaves output register alone; pin reverts to port.
// - output register resets to zero.
// - fully synchronous; prescaled tick is single-cycle enable.
`timescale 1ns/1ps
module tpw_top
(
	// clock and control
	input  wire logic                  CLK,
	input  wire logic                  SRST,
	input  wire logic                  CE,
	// register bus
	input  wire tpw_pkg::tpw_axi_req_t AXI_REQ,
	output tpw_pkg::tpw_axi_rsp_t      AXI_RSP,
	// pins
	output logic                       CMP_OUT_A,
	output logic                       CMP_OUT_B,
	output logic                       PIN_OE_A,
	output logic                       PIN_OE_B,
	output logic                       OVERRIDE_A,
	output logic                       OVERRIDE_B
);
	import tpw_pkg::*;

	tpw_ctrl_t   ctrl_q;
	logic [15:0] cnt_q;
	logic        down_q;
	logic [15:0] cmpa_q;
	logic [15:0] cmpb_q;
	logic [15:0] bufa_q;
	logic [15:0] bufb_q;
	logic [15:0] captop_q;
	logic [3:0]  flags_q;
	logic        oca_q;
	logic        ocb_q;
	logic [9:0]  pre_q;
	logic        tick;
	logic        fast;
	logic        phase;
	logic        pwm;
	logic [15:0] top;
	logic [15:0] mask;
	logic        at_top;
	logic        at_bot;
	logic        load_top;
	logic        mat_a;
	logic        mat_b;
	logic        pc_dn;
	logic        aw_q;
	logic        w_q;
	logic [7:0]  awaddr_q;
	logic [31:0] wdata_q;
	logic        wr_go;
	logic        wr_ok;
	logic [15:0] wval;
	logic [3:0]  flg_clr;
	logic [3:0]  flg_set;

	// mode decode
	always_comb begin
		fast = 1'b0;
		phase = 1'b0;
		top = 16'hFFFF;
		mask = 16'hFFFF;
		unique case (ctrl_q.wgm)
			4'd5: begin fast = 1'b1; top = TOP_8BIT; mask = TOP_8BIT; end
			4'd6: begin fast = 1'b1; top = TOP_9BIT; mask = TOP_9BIT; end
			4'd7: begin fast = 1'b1; top = TOP_10BIT; mask = TOP_10BIT; end
			4'd14: begin fast = 1'b1; top = captop_q; end
			4'd15: begin fast = 1'b1; top = cmpa_q; end
			4'd1: begin phase = 1'b1; top = TOP_8BIT; mask = TOP_8BIT; end
			4'd2: begin phase = 1'b1; top = TOP_9BIT; mask = TOP_9BIT; end
			4'd3: begin phase = 1'b1; top = TOP_10BIT; mask = TOP_10BIT; end
			4'd10: begin phase = 1'b1; top = captop_q; end
			4'd11: begin phase = 1'b1; top = cmpa_q; end
			default: begin fast = 1'b0; end
		endcase
	end
	assign pwm = fast | phase;
	assign at_top = (cnt_q == top);
	assign at_bot = (cnt_q == BOTTOM);
	assign load_top = tick & pwm & at_top;
	assign mat_a = (cnt_q == cmpa_q);
	assign mat_b = (cnt_q == cmpb_q);
	// top match counts as falling slope, bottom match as rising slope
	assign pc_dn = (down_q | at_top) & ~at_bot;

	// prescaler tick
	always_ff @(posedge CLK) begin
		if (SRST) begin
			pre_q <= 10'h000;
		end else if (CE) begin
			pre_q <= pre_q + 10'h001;
		end
	end
	always_comb begin
		unique case (ctrl_q.clk_sel)
			3'd1: tick = 1'b1;
			3'd2: tick = (pre_q[2:0] == DIV_8[2:0]);
			3'd3: tick = (pre_q[5:0] == DIV_64[5:0]);
			3'd4: tick = (pre_q[7:0] == DIV_256[7:0]);
			3'd5: tick = (pre_q == DIV_1024);
			default: tick = 1'b0;
		endcase
	end

	// counter
	always_ff @(posedge CLK) begin
		if (SRST) begin
			cnt_q <= VAL_RST;
			down_q <= 1'b0;
		end else if (CE && tick) begin
			if (fast) begin
				down_q <= 1'b0;
				cnt_q <= at_top ? BOTTOM : cnt_q + 16'h0001;
			end else if (phase) begin
				if (at_top) begin
					down_q <= 1'b1;
					cnt_q <= cnt_q - 16'h0001;
				end else if (down_q && at_bot) begin
					down_q <= 1'b0;
					cnt_q <= cnt_q + 16'h0001;
				end else begin
					cnt_q <= down_q ? cnt_q - 16'h0001 : cnt_q + 16'h0001;
				end
			end else begin
				down_q <= 1'b0;
				cnt_q <= cnt_q + 16'h0001;
			end
		end
	end

	// bus write capture
	assign wr_go = aw_q & w_q & ~AXI_RSP.bvalid;
	assign wval = wdata_q[15:0];
	assign wr_ok = (awaddr_q <= OFS_FLAGS) && (awaddr_q[1:0] == 2'b00);
	always_ff @(posedge CLK) begin
		if (SRST) begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			AXI_RSP.awready <= 1'b0;
			AXI_RSP.wready <= 1'b0;
			AXI_RSP.bvalid <= 1'b0;
			AXI_RSP.bresp <= RESP_OKAY;
		end else if (CE) begin
			AXI_RSP.awready <= ~aw_q & ~AXI_RSP.awready & AXI_REQ.awvalid;
			AXI_RSP.wready <= ~w_q & ~AXI_RSP.wready & AXI_REQ.wvalid;
			if (AXI_RSP.awready && AXI_REQ.awvalid) begin
				aw_q <= 1'b1;
				awaddr_q <= AXI_REQ.awaddr;
			end
			if (AXI_RSP.wready && AXI_REQ.wvalid) begin
				w_q <= 1'b1;
				wdata_q <= AXI_REQ.wdata;
			end
			if (wr_go) begin
				aw_q <= 1'b0;
				w_q <= 1'b0;
				AXI_RSP.bvalid <= 1'b1;
				AXI_RSP.bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (AXI_RSP.bvalid && AXI_REQ.bready) begin
				AXI_RSP.bvalid <= 1'b0;
			end
		end
	end

	// control and capture top registers
	always_ff @(posedge CLK) begin
		if (SRST) begin
			ctrl_q <= CTRL_RST;
			captop_q <= VAL_RST;
		end else if (CE && wr_go) begin
			if (awaddr_q == OFS_CTRL) begin
				ctrl_q <= wdata_q[12:0];
			end
			if (awaddr_q == OFS_CAPTOP) begin
				captop_q <= wval;
			end
		end
	end

	// compare buffers and active values
	always_ff @(posedge CLK) begin
		if (SRST) begin
			bufa_q <= VAL_RST;
			bufb_q <= VAL_RST;
			cmpa_q <= VAL_RST;
			cmpb_q <= VAL_RST;
		end else if (CE) begin
			if (wr_go && awaddr_q == OFS_CMPA) begin
				bufa_q <= wval & mask;
			end
			if (wr_go && awaddr_q == OFS_CMPB) begin
				bufb_q <= wval & mask;
			end
			if (!pwm) begin
				cmpa_q <= bufa_q;
				cmpb_q <= bufb_q;
			end else if (load_top) begin
				cmpa_q <= bufa_q;
				cmpb_q <= bufb_q;
			end
		end
	end

	// flags: hardware set wins over software clear
	assign flg_clr = (wr_go && awaddr_q == OFS_FLAGS) ? wdata_q[3:0] : 4'h0;
	always_comb begin
		flg_set = 4'h0;
		if (tick && pwm) begin
			flg_set[FLG_OVF] = fast ? at_top : (at_bot && down_q);
			flg_set[FLG_CMPA] = mat_a;
			flg_set[FLG_CMPB] = mat_b;
			flg_set[FLG_CAP] = at_top && (ctrl_q.wgm == 4'd14 || ctrl_q.wgm == 4'd10);
		end
	end
	always_ff @(posedge CLK) begin
		if (SRST) begin
			flags_q <= 4'h0;
		end else if (CE) begin
			flags_q <= (flags_q & ~flg_clr) | flg_set;
		end
	end

	// compare output registers
	function automatic logic oc_next(input logic cur, input logic [1:0] com,
		input logic match, input logic wrap, input logic dn, input logic is_fast,
		input logic tog_ok);
		logic nx;
		nx = cur;
		if (com[1]) begin
			if (is_fast) begin
				if (wrap) nx = com[0];
				if (match) nx = com[0] ? 1'b0 : 1'b1;
			end else if (match) begin
				nx = dn ^ com[0];
			end
		end else if (com == COM_TOG && tog_ok && match) begin
			nx = ~cur;
		end
		return nx;
	endfunction

	always_ff @(posedge CLK) begin
		if (SRST) begin
			oca_q <= 1'b0;
			ocb_q <= 1'b0;
		end else if (CE && tick && pwm) begin
			oca_q <= oc_next(oca_q, ctrl_q.com_a, mat_a, at_top, pc_dn, fast,
				ctrl_q.wgm == 4'd15);
			ocb_q <= oc_next(ocb_q, ctrl_q.com_b, mat_b, at_top, pc_dn, fast, 1'b0);
		end
	end

	// pin drive
	always_ff @(posedge CLK) begin
		if (SRST) begin
			CMP_OUT_A <= 1'b0;
			CMP_OUT_B <= 1'b0;
			PIN_OE_A <= 1'b0;
			PIN_OE_B <= 1'b0;
			OVERRIDE_A <= 1'b0;
			OVERRIDE_B <= 1'b0;
		end else if (CE) begin
			CMP_OUT_A <= oca_q;
			CMP_OUT_B <= ocb_q;
			PIN_OE_A <= ctrl_q.dir_a;
			PIN_OE_B <= ctrl_q.dir_b;
			OVERRIDE_A <= ctrl_q.com_a != COM_OFF;
			OVERRIDE_B <= ctrl_q.com_b != COM_OFF;
		end
	end

	// bus read
	always_ff @(posedge CLK) begin
		if (SRST) begin
			AXI_RSP.arready <= 1'b0;
			AXI_RSP.rvalid <= 1'b0;
			AXI_RSP.rdata <= 32'h0000_0000;
			AXI_RSP.rresp <= RESP_OKAY;
		end else if (CE) begin
			AXI_RSP.arready <= ~AXI_RSP.arready & ~AXI_RSP.rvalid & AXI_REQ.arvalid;
			if (AXI_RSP.arready && AXI_REQ.arvalid) begin
				AXI_RSP.rvalid <= 1'b1;
				AXI_RSP.rresp <= RESP_OKAY;
				unique case (AXI_REQ.araddr)
					OFS_CTRL: AXI_RSP.rdata <= {19'h0_0000, ctrl_q};
					OFS_CNT: AXI_RSP.rdata <= {16'h0000, cnt_q};
					OFS_CMPA: AXI_RSP.rdata <= {16'h0000, bufa_q};
					OFS_CMPB: AXI_RSP.rdata <= {16'h0000, bufb_q};
					OFS_CAPTOP: AXI_RSP.rdata <= {16'h0000, captop_q};
					OFS_FLAGS: AXI_RSP.rdata <= {28'h000_0000, flags_q};
					default: begin
						AXI_RSP.rdata <= 32'h0000_0000;
						AXI_RSP.rresp <= RESP_SLVERR;
					end
				endcase
			end else if (AXI_RSP.rvalid && AXI_REQ.rready) begin
				AXI_RSP.rvalid <= 1'b0;
			end
		end
	end

	// checks
	property p_fast_wrap;
		@(posedge CLK) disable iff (SRST) CE && tick && fast && at_top |=> cnt_q == BOTTOM;
	endproperty
	a_fast_wrap: assert property (p_fast_wrap) else $error("fast pwm did not wrap");
	property p_fast_ovf;
		@(posedge CLK) disable iff (SRST) CE && tick && fast && at_top |=> flags_q[FLG_OVF];
	endproperty
	a_fast_ovf: assert property (p_fast_ovf) else $error("overflow flag missing");
	property p_pc_ovf;
		@(posedge CLK) disable iff (SRST)
			CE && tick && phase && at_bot && down_q |=> flags_q[FLG_OVF];
	endproperty
	a_pc_ovf: assert property (p_pc_ovf) else $error("bottom overflow missing");
	property p_turn;
		@(posedge CLK) disable iff (SRST)
			CE && tick && phase && at_top && !at_bot |=> down_q && cnt_q == $past(cnt_q) - 16'h0001;
	endproperty
	a_turn: assert property (p_turn) else $error("phase turn wrong");
	property p_load;
		@(posedge CLK) disable iff (SRST) CE && load_top |=> cmpa_q == $past(bufa_q);
	endproperty
	a_load: assert property (p_load) else $error("buffer not loaded");
	property p_cmpf;
		@(posedge CLK) disable iff (SRST) CE && tick && pwm && mat_b |=> flags_q[FLG_CMPB];
	endproperty
	a_cmpf: assert property (p_cmpf) else $error("compare flag missing");
	property p_hold_off;
		@(posedge CLK) disable iff (SRST) CE && ctrl_q.com_a == COM_OFF |=> $stable(oca_q);
	endproperty
	a_hold_off: assert property (p_hold_off) else $error("output moved in mode 0");
	property p_oe;
		@(posedge CLK) disable iff (SRST) CE |=> PIN_OE_A == $past(ctrl_q.dir_a);
	endproperty
	a_oe: assert property (p_oe) else $error("direction not followed");

	c_fast: cover property (@(posedge CLK) disable iff (SRST) tick && fast && at_top);
	c_pc: cover property (@(posedge CLK) disable iff (SRST) tick && phase && at_bot && down_q);
	c_tog: cover property (@(posedge CLK) disable iff (SRST) oca_q && ctrl_q.com_a == COM_TOG);
endmodule

// File: sim/tpw_pin_model.sv
// port pin model: output driver, port mux and pull-up on the pad
`timescale 1ns/1ps
module tpw_pin_model (
	// pin controls
	input  wire logic oe,
	input  wire logic ovr,
	input  wire logic cmp,
	input  wire logic port_val,
	// pad level
	output logic      pin
);
	assign pin = oe ? (ovr ? cmp : port_val) : 1'b1;
endmodule

// File: sim/test_tpw_top.sv
// self-checking bench for the timer pwm block
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fails++; \
	$display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module test_tpw_top;
	import tpw_pkg::*;
	logic         clk, srst, port_a, ce, lvl;
	tpw_axi_req_t req;
	tpw_axi_rsp_t rsp;
	logic         oa, ob, oea, oeb, ova, ovb, pin_a, pin_b;
	logic [31:0]  rd;
	logic [1:0]   rs;
	int           fails, checks_done, hi, per, t, ca, cb, p, ha, hb, m, coa, ex;
	int           exp_q[$];
	int           modes[10] = '{5, 6, 7, 14, 15, 1, 2, 3, 10, 11};
	int           divs[5] = '{1, 8, 64, 256, 1024};
	int           fixm[6] = '{1, 2, 3, 5, 6, 7};

	tpw_top i_dut (.CLK(clk), .SRST(srst), .CE(ce), .AXI_REQ(req), .AXI_RSP(rsp),
		.CMP_OUT_A(oa), .CMP_OUT_B(ob), .PIN_OE_A(oea), .PIN_OE_B(oeb),
		.OVERRIDE_A(ova), .OVERRIDE_B(ovb));
	tpw_pin_model i_pa (.oe(oea), .ovr(ova), .cmp(oa), .port_val(port_a), .pin(pin_a));
	tpw_pin_model i_pb (.oe(oeb), .ovr(ovb), .cmp(ob), .port_val(1'b0), .pin(pin_b));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] dt);
		bit ad;
		bit wd;
		ad = 0;
		wd = 0;
		@(posedge clk);
		req.awaddr <= a;
		req.wdata <= dt;
		req.wstrb <= 4'hF;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge clk);
			if (rsp.awready === 1'b1) begin
				ad = 1;
				req.awvalid <= 1'b0;
			end
			if (rsp.wready === 1'b1) begin
				wd = 1;
				req.wvalid <= 1'b0;
			end
		end
		do @(posedge clk); while (rsp.bvalid !== 1'b1);
		rs = rsp.bresp;
		req.bready <= 1'b0;
	endtask

	task automatic rdr(input logic [7:0] a);
		@(posedge clk);
		req.araddr <= a;
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		do @(posedge clk); while (rsp.arready !== 1'b1);
		req.arvalid <= 1'b0;
		do @(posedge clk); while (rsp.rvalid !== 1'b1);
		rd = rsp.rdata;
		rs = rsp.rresp;
		req.rready <= 1'b0;
	endtask

	function automatic logic lv(input bit b);
		return b ? pin_b : pin_a;
	endfunction

	// high time and period of a pin, from one rising edge to the next
	task automatic meas(input bit b);
		while (lv(b) !== 1'b0) @(posedge clk);
		while (lv(b) !== 1'b1) @(posedge clk);
		hi = 0;
		while (lv(b) === 1'b1) begin
			@(posedge clk);
			hi++;
		end
		per = hi;
		while (lv(b) === 1'b0) begin
			@(posedge clk);
			per++;
		end
	endtask

	task automatic flat(input bit b, input int k, input logic e);
		repeat (k) begin
			@(posedge clk);
			`CHK(lv(b), e)
		end
	endtask

	// reset, load compares while unbuffered, then start; channel b inverted
	task automatic cfg(input int md, input int tp, input int a, input int b, input int cs,
		input int co);
		@(posedge clk);
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		wr(OFS_CMPA, 32'(a));
		wr(OFS_CMPB, 32'(b));
		wr(OFS_CAPTOP, 32'(tp));
		wr(OFS_CTRL, {19'h0, 2'b11, 3'(cs), 2'h3, 2'(co), 4'(md)});
	endtask

	task automatic report_and_stop();
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		repeat (100000) @(posedge clk);
		fails++;
		report_and_stop();
	end

	initial begin
		req = '0;
		ce = 1'b1;
		srst = 1'b1;
		port_a = 1'b0;
		fails = 0;
		checks_done = 0;
		void'($urandom(32'h1ca4c809));
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		port_a <= 1'($urandom % 2);
		@(posedge clk);
		`CHK(oa, 1'b0)
		`CHK(pin_a, 1'b1)
		rdr(OFS_CAPTOP);
		`CHK(rd, {16'h0, VAL_RST})
		wr(OFS_CTRL, {19'h0, 2'b01, 3'h0, 2'h0, 2'h0, 4'd14});
		repeat (3) @(posedge clk);
		`CHK(ova, 1'b0)
		`CHK(oea, 1'b1)
		`CHK(pin_a, port_a)
		wr(8'h18, 32'h1);
		`CHK(rs, RESP_SLVERR)
		rdr(8'h1C);
		`CHK(rs, RESP_SLVERR)
		`CHK(rd, 32'h0)
		foreach (fixm[i]) begin
			wr(OFS_CTRL, 32'(fixm[i]));
			wr(OFS_CMPA, 32'hFFFF);
			rdr(OFS_CMPA);
			`CHK(rd, 32'((256 << ((fixm[i] & 3) - 1)) - 1))
		end
		foreach (modes[i]) begin
			m = modes[i];
			t = (m inside {10, 11, 14, 15}) ? 3 + $urandom % 30 : (256 << ((m & 3) - 1)) - 1;
			ca = (m inside {11, 15}) ? t : 1 + $urandom % (t - 1);
			cb = 1 + $urandom % (t - 1);
			coa = (m == 15) ? 1 : 2;
			cfg(m, t, ca, cb, 1, coa);
			if (m inside {[5:7], 14, 15}) begin
				p = t + 1;
				hb = cb + 1;
				ha = (m == 15) ? t + 1 : t - ca;
			end else begin
				p = 2 * t;
				hb = 2 * (t - cb);
				ha = 2 * ca;
			end
			exp_q = '{p, hb, (m == 15) ? 2 * p : p, ha};
			meas(1);
			ex = exp_q.pop_front();
			`CHK(per, ex)
			ex = exp_q.pop_front();
			`CHK(hi, ex)
			if (m == 11) begin
				flat(0, p, 1'b1);
			end else begin
				meas(0);
				ex = exp_q.pop_front();
				`CHK(per, ex)
				ex = exp_q.pop_front();
				`CHK(hi, ex)
			end
			wr(OFS_CTRL, {19'h0, 2'b11, 3'h0, 2'h3, 2'(coa), 4'(m)});
			rdr(OFS_CNT);
			`CHK(rd[15:0] <= 16'(t), 1'b1)
			rdr(OFS_FLAGS);
			`CHK(rd, 32'((m inside {10, 14}) ? 15 : 7))
			wr(OFS_FLAGS, 32'hF);
			rdr(OFS_FLAGS);
			`CHK(rd, 32'h0)
		end
		cfg(14, 20, 0, 1, 1, 2);
		meas(0);
		`CHK(hi, 20)
		`CHK(per, 21)
		cfg(10, 20, 0, 20, 1, 2);
		repeat (50) @(posedge clk);
		flat(0, 100, 1'b0);
		flat(1, 100, 1'b0);
		foreach (divs[j]) begin
			cfg(14, 3, 1, 1, j + 1, 2);
			meas(1);
			`CHK(per, 4 * divs[j])
			`CHK(hi, 2 * divs[j])
		end
		// clock enable low freezes the running waveform
		cfg(14, 3, 1, 1, 1, 2);
		repeat (9) @(posedge clk);
		ce <= 1'b0;
		@(posedge clk);
		lvl = pin_b;
		repeat (12) begin
			@(posedge clk);
			`CHK(pin_b, lvl)
		end
		ce <= 1'b1;
		meas(1);
		`CHK(per, 4)
		report_and_stop();
	end
endmodule
